// >>> accel_pkg.sv
// constants for the three-axis accelerometer digital core
// assumes a 50 MHz core clock and a serial register bus on its own link clock
package accel_pkg;
    localparam int MCLK_HZ = 50_000_000;
    localparam int OUTPUT_RATE_HZ = 100;
    localparam int RATE_CYCLES = MCLK_HZ / OUTPUT_RATE_HZ;

    // range codes and matching sensitivity in counts per g
    localparam logic [1:0] FSR_2G = 2'h0;
    localparam logic [1:0] FSR_4G = 2'h1;
    localparam logic [1:0] FSR_8G = 2'h2;
    localparam logic [1:0] FSR_BAD = 2'h3;
    localparam int COUNTS_PER_G_2G = 1024;
    localparam int COUNTS_PER_G_4G = 512;
    localparam int COUNTS_PER_G_8G = 256;

    localparam logic [6:0] BUS_ADDR_BASE = 7'h10;

    // register pointers on the serial bus
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CLEAR = 8'h01;
    localparam logic [7:0] REG_X_HI = 8'h03;
    localparam logic [7:0] REG_X_LO = 8'h04;
    localparam logic [7:0] REG_Y_HI = 8'h05;
    localparam logic [7:0] REG_Y_LO = 8'h06;
    localparam logic [7:0] REG_Z_HI = 8'h07;
    localparam logic [7:0] REG_Z_LO = 8'h08;
    localparam logic [7:0] REG_TEMP = 8'h09;
    localparam logic [7:0] REG_CTRL = 8'h0d;
    localparam logic [7:0] REG_THRESH = 8'h0e;

    localparam int CTRL_PD_BIT = 0;
    localparam int CTRL_FSR_LSB = 5;
    localparam int CLR_ORIENT_BIT = 0;
    localparam int CLR_SHAKE_BIT = 1;
    localparam int THRESH_SHIFT = 4;

    localparam logic [1:0] FSR_RST = FSR_2G;
    localparam logic [7:0] THRESH_RST = 8'h40;

    localparam logic [1:0] CH_X = 2'h0;
    localparam logic [1:0] CH_TEMP = 2'h3;

    // orientation codes
    localparam logic [2:0] ORI_XP = 3'h0;
    localparam logic [2:0] ORI_XN = 3'h1;
    localparam logic [2:0] ORI_YP = 3'h2;
    localparam logic [2:0] ORI_YN = 3'h3;
    localparam logic [2:0] ORI_ZP = 3'h4;
    localparam logic [2:0] ORI_ZN = 3'h5;
endpackage

// >>> accel_core.sv
// accelerometer digital core: conversion sequencer, detectors, serial slave
// assumes an analog path that converts one channel per start pulse,
// open-drain pads outside, and a free-running oversampling link clock
//
// Notes on behaviour
// - range codes 0,1,2 give 2g,4g,8g
// - x, y, z readable as 12-bit results
// - temperature readable as 8-bit raw count
// - one path converts x, y, z, temp in turn
// - conversion cycle starts at 100 per second
// - bus address is 0x10 plus strap code
// - six orientations, x/y shake with direction
// - shake compared against host-written threshold
// - interrupt pin always mirrors interrupt flag
// - flag on orientation change or shake event
// - interrupt pin pulled low when active
// - writing ones to clear register drops flag
// - host enters/leaves power-down by register write
// - slave only, bus up to 400 kHz
// - first write byte loads register pointer
// - later bytes stored, pointer then increments
`timescale 1ns/1ps
`default_nettype none
module accel_core #(
    parameter int RATE_CYCLES = accel_pkg::RATE_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic int_n_o,
    output logic int_n_oe_o,
    input wire logic [2:0] addr_code_i,
    output logic conv_start_o,
    output logic [1:0] conv_chan_o,
    input wire logic conv_done_i,
    input wire logic [11:0] conv_data_i,
    output logic [1:0] full_scale_select_o,
    output logic power_down_o
);
    localparam int RW = $clog2(RATE_CYCLES);
    localparam logic [RW-1:0] RATE_LAST = RW'(RATE_CYCLES - 1);

    typedef enum logic [2:0] {L_IDLE, L_ADDR, L_PTR, L_WR, L_ACK, L_RD, L_RACK} lst_t;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_q;
        logic sda_q;
        logic [2:0] addr_s1;
        logic [2:0] addr_s2;
        logic [1:0] ack_sync;
        lst_t st;
        lst_t nxt;
        logic [3:0] bits;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic sda_oe;
        logic sda_lo;
        logic req_tgl;
        logic req_wr;
        logic [7:0] req_ptr;
        logic [7:0] req_wdata;
    } link_t;

    typedef struct packed {
        logic [2:0] req_sync;
        logic ack_tgl;
        logic [7:0] rdata;
        logic pd;
        logic [1:0] full_scale_select;
        logic [7:0] thr;
        logic [2:0][11:0] res;
        logic [7:0] temp;
        logic [2:0] orient;
        logic [2:0] ref_orient;
        logic x_dir;
        logic y_dir;
        logic orient_chg;
        logic shake_evt;
        logic busy;
        logic [1:0] chan;
        logic start;
        logic eval;
        logic [RW-1:0] rate_cnt;
        logic int_oe;
        logic int_lo;
    } core_t;

    link_t l_reg, l_next;
    core_t c_reg, c_next;

    logic [2:0][11:0] mag;
    logic [2:0] neg;
    for (genvar g = 0; g < 3; g++) begin : g_mag
        assign neg[g] = c_reg.res[g][11];
        assign mag[g] = neg[g] ? 12'(-c_reg.res[g]) : c_reg.res[g];
    end

    // ---------------- link side ----------------
    always_comb begin
        logic rise, fall, start, stop;
        logic [6:0] own;
        rise = 1'b0;
        fall = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        own = 7'h00;
        l_next = l_reg;
        l_next.rst_sync = {l_reg.rst_sync[0], rst_n_i};
        l_next.scl_sync = {l_reg.scl_sync[0], scl_i};
        l_next.sda_sync = {l_reg.sda_sync[0], sda_i};
        l_next.scl_q = l_reg.scl_sync[1];
        l_next.sda_q = l_reg.sda_sync[1];
        l_next.addr_s1 = addr_code_i;
        l_next.addr_s2 = l_reg.addr_s1;
        l_next.ack_sync = {l_reg.ack_sync[0], c_reg.ack_tgl};
        rise = l_reg.scl_sync[1] & ~l_reg.scl_q;
        fall = ~l_reg.scl_sync[1] & l_reg.scl_q;
        start = l_reg.scl_sync[1] & l_reg.scl_q & l_reg.sda_q & ~l_reg.sda_sync[1];
        stop = l_reg.scl_sync[1] & l_reg.scl_q & ~l_reg.sda_q & l_reg.sda_sync[1];
        own = accel_pkg::BUS_ADDR_BASE | {4'h0, l_reg.addr_s2};
        if (stop) begin
            l_next.st = L_IDLE;
            l_next.sda_oe = 1'b0;
        end else if (start) begin
            l_next.st = L_ADDR;
            l_next.bits = 4'h0;
            l_next.sda_oe = 1'b0;
        end else begin
            unique case (l_reg.st)
                L_IDLE: ;
                L_ADDR, L_PTR, L_WR: begin
                    if (rise && l_reg.bits < 4'h8) begin
                        l_next.shreg = {l_reg.shreg[6:0], l_reg.sda_sync[1]};
                        l_next.bits = l_reg.bits + 4'h1;
                    end
                    if (fall && l_reg.bits == 4'h8) begin
                        l_next.sda_oe = 1'b1;
                        l_next.st = L_ACK;
                        if (l_reg.st == L_ADDR) begin
                            if (l_reg.shreg[7:1] != own) begin
                                l_next.sda_oe = 1'b0;
                                l_next.st = L_IDLE;
                            end else if (l_reg.shreg[0]) begin
                                l_next.req_tgl = ~l_reg.req_tgl;
                                l_next.req_wr = 1'b0;
                                l_next.req_ptr = l_reg.ptr;
                                l_next.ptr = l_reg.ptr + 8'h1;
                                l_next.nxt = L_RD;
                            end else begin
                                l_next.nxt = L_PTR;
                            end
                        end else if (l_reg.st == L_PTR) begin
                            l_next.ptr = l_reg.shreg;
                            l_next.nxt = L_WR;
                        end else begin
                            l_next.req_tgl = ~l_reg.req_tgl;
                            l_next.req_wr = 1'b1;
                            l_next.req_ptr = l_reg.ptr;
                            l_next.req_wdata = l_reg.shreg;
                            l_next.ptr = l_reg.ptr + 8'h1;
                            l_next.nxt = L_WR;
                        end
                    end
                end
                L_ACK: begin
                    if (fall) begin
                        l_next.bits = 4'h0;
                        l_next.sda_oe = 1'b0;
                        l_next.st = l_reg.nxt;
                        if (l_reg.nxt == L_RD) begin
                            l_next.shreg = (l_reg.ack_sync[1] == l_reg.req_tgl) ?
                                c_reg.rdata : 8'hff;
                            l_next.sda_oe = ~l_next.shreg[7];
                        end
                    end
                end
                L_RD: begin
                    if (rise) begin
                        l_next.bits = l_reg.bits + 4'h1;
                    end
                    if (fall) begin
                        if (l_reg.bits == 4'h8) begin
                            l_next.sda_oe = 1'b0;
                            l_next.st = L_RACK;
                        end else begin
                            l_next.shreg = {l_reg.shreg[6:0], 1'b1};
                            l_next.sda_oe = ~l_reg.shreg[6];
                        end
                    end
                end
                L_RACK: begin
                    if (rise) begin
                        if (!l_reg.sda_sync[1]) begin
                            l_next.req_tgl = ~l_reg.req_tgl;
                            l_next.req_wr = 1'b0;
                            l_next.req_ptr = l_reg.ptr;
                            l_next.ptr = l_reg.ptr + 8'h1;
                            l_next.nxt = L_RD;
                            l_next.st = L_ACK;
                        end else begin
                            l_next.st = L_IDLE;
                        end
                    end
                end
            endcase
        end
        if (!l_reg.rst_sync[1]) begin
            l_next.st = L_IDLE;
            l_next.nxt = L_IDLE;
            l_next.bits = 4'h0;
            l_next.shreg = 8'h00;
            l_next.ptr = 8'h00;
            l_next.sda_oe = 1'b0;
            l_next.req_tgl = 1'b0;
            l_next.req_wr = 1'b0;
            l_next.req_ptr = 8'h00;
            l_next.req_wdata = 8'h00;
        end
        l_next.sda_lo = 1'b0;
    end

    always_ff @(posedge link_clk_i) begin
        l_reg <= l_next;
    end

    // ---------------- core side ----------------
    always_comb begin
        logic new_req;
        logic [2:0] ori;
        logic [11:0] thr_ext;
        logic sx, sy;
        new_req = 1'b0;
        ori = accel_pkg::ORI_XP;
        thr_ext = 12'h000;
        sx = 1'b0;
        sy = 1'b0;
        c_next = c_reg;
        c_next.start = 1'b0;
        c_next.eval = 1'b0;
        c_next.req_sync = {c_reg.req_sync[1:0], l_reg.req_tgl};
        new_req = c_reg.req_sync[2] ^ c_reg.req_sync[1];
        if (mag[0] >= mag[1] && mag[0] >= mag[2]) begin
            ori = neg[0] ? accel_pkg::ORI_XN : accel_pkg::ORI_XP;
        end else if (mag[1] >= mag[2]) begin
            ori = neg[1] ? accel_pkg::ORI_YN : accel_pkg::ORI_YP;
        end else begin
            ori = neg[2] ? accel_pkg::ORI_ZN : accel_pkg::ORI_ZP;
        end
        thr_ext = {c_reg.thr, 4'h0} >> (4 - accel_pkg::THRESH_SHIFT);
        sx = mag[0] > thr_ext;
        sy = mag[1] > thr_ext;
        // register accesses from the link; clears go before sets
        if (new_req) begin
            c_next.ack_tgl = ~c_reg.ack_tgl;
            if (l_reg.req_wr) begin
                unique case (l_reg.req_ptr)
                    accel_pkg::REG_CLEAR: begin
                        if (l_reg.req_wdata[accel_pkg::CLR_ORIENT_BIT]) begin
                            c_next.orient_chg = 1'b0;
                        end
                        if (l_reg.req_wdata[accel_pkg::CLR_SHAKE_BIT]) begin
                            c_next.shake_evt = 1'b0;
                        end
                    end
                    accel_pkg::REG_CTRL: begin
                        c_next.pd = l_reg.req_wdata[accel_pkg::CTRL_PD_BIT];
                        if (l_reg.req_wdata[accel_pkg::CTRL_FSR_LSB+:2] != accel_pkg::FSR_BAD) begin
                            c_next.full_scale_select = l_reg.req_wdata[accel_pkg::CTRL_FSR_LSB+:2];
                        end
                    end
                    accel_pkg::REG_THRESH: c_next.thr = l_reg.req_wdata;
                    default: ;
                endcase
            end else begin
                unique case (l_reg.req_ptr)
                    accel_pkg::REG_STATUS: begin
                        c_next.rdata = {c_reg.int_oe, c_reg.shake_evt, c_reg.orient_chg,
                                        c_reg.orient, c_reg.x_dir, c_reg.y_dir};
                        c_next.ref_orient = c_reg.orient;
                    end
                    accel_pkg::REG_X_HI: c_next.rdata = c_reg.res[0][11:4];
                    accel_pkg::REG_X_LO: c_next.rdata = {c_reg.res[0][3:0], 4'h0};
                    accel_pkg::REG_Y_HI: c_next.rdata = c_reg.res[1][11:4];
                    accel_pkg::REG_Y_LO: c_next.rdata = {c_reg.res[1][3:0], 4'h0};
                    accel_pkg::REG_Z_HI: c_next.rdata = c_reg.res[2][11:4];
                    accel_pkg::REG_Z_LO: c_next.rdata = {c_reg.res[2][3:0], 4'h0};
                    accel_pkg::REG_TEMP: c_next.rdata = c_reg.temp;
                    accel_pkg::REG_CTRL: c_next.rdata = {1'b0, c_reg.full_scale_select, 4'h0, c_reg.pd};
                    accel_pkg::REG_THRESH: c_next.rdata = c_reg.thr;
                    default: c_next.rdata = 8'h00;
                endcase
            end
        end
        // sequencer: one path, channels in turn
        if (c_reg.pd) begin
            c_next.rate_cnt = '0;
            c_next.busy = 1'b0;
        end else begin
            c_next.rate_cnt = (c_reg.rate_cnt == RATE_LAST) ? '0 : c_reg.rate_cnt + 1'b1;
            if (c_reg.rate_cnt == RATE_LAST && !c_reg.busy) begin
                c_next.busy = 1'b1;
                c_next.chan = accel_pkg::CH_X;
                c_next.start = 1'b1;
            end else if (c_reg.busy && conv_done_i) begin
                if (c_reg.chan == accel_pkg::CH_TEMP) begin
                    c_next.temp = conv_data_i[7:0];
                    c_next.busy = 1'b0;
                    c_next.eval = 1'b1;
                end else begin
                    c_next.res[c_reg.chan] = conv_data_i;
                    c_next.chan = c_reg.chan + 2'h1;
                    c_next.start = 1'b1;
                end
            end
        end
        if (c_reg.eval) begin
            c_next.orient = ori;
            if (ori != c_reg.ref_orient) begin
                c_next.orient_chg = 1'b1;
            end
            if (sx || sy) begin
                c_next.shake_evt = 1'b1;
                c_next.x_dir = neg[0];
                c_next.y_dir = neg[1];
            end
        end
        c_next.int_oe = c_next.orient_chg | c_next.shake_evt;
        c_next.int_lo = 1'b0;
        if (!rst_n_i) begin
            c_next = '0;
            c_next.full_scale_select = accel_pkg::FSR_RST;
            c_next.thr = accel_pkg::THRESH_RST;
        end
    end

    always_ff @(posedge mclk_i) begin
        c_reg <= c_next;
    end

    assign sda_o = l_reg.sda_lo;
    assign sda_oe_o = l_reg.sda_oe;
    assign int_n_o = c_reg.int_lo;
    assign int_n_oe_o = c_reg.int_oe;
    assign conv_start_o = c_reg.start;
    assign conv_chan_o = c_reg.chan;
    assign full_scale_select_o = c_reg.full_scale_select;
    assign power_down_o = c_reg.pd;

    AST_INT_MIRROR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        int_n_oe_o == (c_reg.orient_chg | c_reg.shake_evt)) else $error("int pin off flag");
    AST_FSR_LEGAL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        full_scale_select_o != accel_pkg::FSR_BAD) else $error("illegal range");
    AST_SEQ_ORDER: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        conv_start_o && conv_chan_o != 2'h0 |-> $past(conv_chan_o) == conv_chan_o - 2'h1)
        else $error("channel order broken");
    AST_PD_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        power_down_o && $past(power_down_o) |-> !conv_start_o) else $error("convert in pd");
    AST_RATE_TICK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        c_reg.rate_cnt == RATE_LAST && !c_reg.pd && !c_reg.busy
        |=> conv_start_o && conv_chan_o == 2'h0) else $error("cycle not started");
    AST_SET_ORIENT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        c_reg.eval && c_reg.ref_orient != c_next.orient |=> c_reg.orient_chg && int_n_oe_o)
        else $error("orientation change missed");
    AST_ADDR_ACK: assert property (@(posedge link_clk_i) disable iff (!l_reg.rst_sync[1])
        l_reg.st == L_ADDR && l_reg.bits == 4'h8 && l_reg.scl_q && !l_reg.scl_sync[1]
        && l_reg.shreg[7:1] == (accel_pkg::BUS_ADDR_BASE | {4'h0, l_reg.addr_s2})
        && !(l_reg.scl_sync[1] && l_reg.scl_q) |=> sda_oe_o && l_reg.st == L_ACK)
        else $error("own address not acknowledged");
    AST_PTR_LOAD: assert property (@(posedge link_clk_i) disable iff (!l_reg.rst_sync[1])
        l_reg.st == L_PTR && l_reg.bits == 4'h8 && l_reg.scl_q && !l_reg.scl_sync[1]
        |=> l_reg.ptr == $past(l_reg.shreg) && l_reg.nxt == L_WR) else $error("pointer not loaded");
    AST_PTR_INC: assert property (@(posedge link_clk_i) disable iff (!l_reg.rst_sync[1])
        l_reg.st == L_WR && l_reg.bits == 4'h8 && l_reg.scl_q && !l_reg.scl_sync[1]
        |=> l_reg.ptr == $past(l_reg.ptr) + 8'h1 && l_reg.req_tgl != $past(l_reg.req_tgl))
        else $error("write byte not stored");
endmodule // accel_core
`default_nettype wire

// >>> accel_i2c_host.sv
// behavioural serial bus master for the accelerometer bench
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
module accel_i2c_host (
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o,
    output logic [7:0] rd_data_o,
    output logic rd_strobe_o
);
    localparam int T = 850;

    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        rd_data_o = 8'h00;
        rd_strobe_o = 1'b0;
    end

    // low 2T, high T: 392 kHz, data moves mid-low, sampled at end of high
    task automatic bit_x(input logic b, output logic s);
        #T sda_oe_o = ~b;
        #T scl_oe_o = 1'b0;
        #T s = sda_i;
        scl_oe_o = 1'b1;
    endtask

    // also serves as repeated start
    task automatic bus_start();
        #T sda_oe_o = 1'b0;
        #T scl_oe_o = 1'b0;
        #T sda_oe_o = 1'b1;
        #T scl_oe_o = 1'b1;
    endtask

    task automatic bus_stop();
        #T sda_oe_o = 1'b1;
        #T scl_oe_o = 1'b0;
        #T sda_oe_o = 1'b0;
        #T;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], s);
        bit_x(1'b1, ack_n);
    endtask

    task automatic recv_byte(input logic last);
        logic [7:0] d;
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, s);
        rd_data_o = d;
        rd_strobe_o = 1'b1;
        #10 rd_strobe_o = 1'b0;
    endtask
endmodule // accel_i2c_host
`default_nettype wire

// >>> triaxial_accel_readout_int_bench.sv
// self-checking bench for the accelerometer core
// assumes accel_pkg, accel_core and accel_i2c_host compiled before it
`timescale 1ns/1ps
`default_nettype none
module triaxial_accel_readout_int_bench;
    localparam int RATE = 200;
    logic mclk_i = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] code = 3'h0;
    logic conv_done = 1'b0;
    logic [11:0] conv_data = 12'h000;
    logic sda_o, sda_oe, int_n, int_n_oe, conv_start, pd, h_scl, h_sda, rd_stb, ack_n;
    logic [1:0] chan, full_scale_select;
    logic [7:0] rd_data;
    logic [11:0] ch_val [4];
    logic [15:0] exp_q [$];
    logic [7:0] wq [$];
    logic [1:0] fc [3] = '{2'h2, 2'h3, 2'h0};
    logic [1:0] fe [3] = '{2'h2, 2'h2, 2'h0};
    logic [1:0] next_ch = 2'h0;
    logic seen = 1'b0;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int since = 0;
    wire scl_w = ~h_scl;
    wire sda_w = (sda_oe ? sda_o : 1'b1) & ~h_sda;
    wire int_w = int_n_oe ? int_n : 1'b1;

    always #10 mclk_i = ~mclk_i;
    initial #3 forever #15 link_clk = ~link_clk;

    accel_core #(.RATE_CYCLES(RATE)) DUT (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk), .scl_i(scl_w),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .int_n_o(int_n),
        .int_n_oe_o(int_n_oe), .addr_code_i(code), .conv_start_o(conv_start),
        .conv_chan_o(chan), .conv_done_i(conv_done), .conv_data_i(conv_data),
        .full_scale_select_o(full_scale_select), .power_down_o(pd));

    accel_i2c_host host (.sda_i(sda_w), .scl_oe_o(h_scl), .sda_oe_o(h_sda),
        .rd_data_o(rd_data), .rd_strobe_o(rd_stb));

    task automatic complete_run();
        if (exp_q.size() != 0) fails++;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [15:0] n);
        checks++;
        if ((got & n[15:8]) !== (n[7:0] & n[15:8])) begin
            fails++;
            $display("CHECK FAILED at %0t: read %h expected %h", $time, got, n[7:0]);
        end
    endtask

    task automatic note(input logic [7:0] m, input logic [7:0] e);
        exp_q.push_back({m, e});
    endtask

    task automatic snd(input logic [7:0] d);
        host.send_byte(d, ack_n);
        check_val({11'h0, ack_n}, 12'h000);
    endtask

    task automatic wr_regs(input logic [7:0] ptr);
        host.bus_start();
        snd({4'h2, code, 1'b0});
        snd(ptr);
        foreach (wq[i]) snd(wq[i]);
        host.bus_stop();
        wq = {};
    endtask

    task automatic wr1(input logic [7:0] ptr, input logic [7:0] v);
        wq = '{v};
        wr_regs(ptr);
    endtask

    task automatic rd_regs(input logic [7:0] ptr, input int n);
        host.bus_start();
        snd({4'h2, code, 1'b0});
        snd(ptr);
        host.bus_start();
        snd({4'h2, code, 1'b1});
        for (int i = 0; i < n; i++) host.recv_byte(i == n - 1);
        host.bus_stop();
    endtask

    task automatic settle();
        repeat (600) @(posedge mclk_i);
    endtask

    // read bytes are matched against the oldest note
    always @(posedge rd_stb) begin
        if (exp_q.size() == 0) check_val(12'h001, 12'h000);
        else check_byte(rd_data, exp_q.pop_front());
    end

    // channel order, start spacing, no starts while powered down
    always @(posedge mclk_i) begin
        cyc++;
        since++;
        if (cyc > 95000) begin
            fails++;
            complete_run();
        end
        if (pd === 1'b1) begin
            next_ch = 2'h0;
            seen = 1'b0;
        end
        if (conv_start === 1'b1) begin
            check_val({10'h0, chan}, {10'h0, next_ch});
            check_val({11'h0, pd}, 12'h000);
            if (chan === 2'h0) begin
                if (seen) check_val(12'(since), 12'(RATE));
                seen = 1'b1;
                since = 0;
            end
            next_ch = chan + 2'h1;
        end
    end

    // analog path answers each start three cycles later
    always begin
        @(posedge mclk_i);
        if (conv_start === 1'b1) begin
            repeat (3) @(posedge mclk_i);
            #1 conv_data = ch_val[chan];
            conv_done = 1'b1;
            @(posedge mclk_i);
            #1 conv_done = 1'b0;
        end
    end

    initial begin
        void'($urandom(9));
        code = 3'($urandom_range(7));
        ch_val = '{12'h400, 12'h010, 12'h020, 12'h055};
        repeat (8) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        check_val({9'h0, int_n_oe, full_scale_select, pd}, 12'h000);
        host.bus_start();
        host.send_byte({4'h3, code, 1'b0}, ack_n);
        check_val({11'h0, ack_n}, 12'h001);
        host.bus_stop();
        note(8'hff, 8'h00);
        note(8'hff, 8'h40);
        rd_regs(8'h0d, 2);
        settle();
        note(8'h1c, 8'h00);
        rd_regs(8'h00, 1);
        wr1(8'h01, 8'h03);
        settle();
        check_val({10'h0, int_n_oe, int_w}, 12'h001);
        ch_val[1] = 12'ha00;
        settle();
        check_val({10'h0, int_n_oe, int_w}, 12'h002);
        note(8'hff, 8'hed);
        rd_regs(8'h00, 1);
        ch_val[1] = 12'h010;
        settle();
        wr1(8'h01, 8'h02);
        settle();
        check_val({10'h0, int_n_oe, int_w}, 12'h002);
        note(8'hfc, 8'ha0);
        rd_regs(8'h00, 1);
        wr1(8'h01, 8'h01);
        settle();
        check_val({10'h0, int_n_oe, int_w}, 12'h001);
        wq = '{8'h20, 8'h30};
        wr_regs(8'h0d);
        settle();
        check_val({10'h0, full_scale_select}, 12'h001);
        check_val({10'h0, int_n_oe, int_w}, 12'h002);
        note(8'hff, 8'h20);
        note(8'hff, 8'h30);
        rd_regs(8'h0d, 2);
        foreach (fc[i]) begin
            wr1(8'h0d, {1'b0, fc[i], 5'h00});
            check_val({10'h0, full_scale_select}, {10'h0, fe[i]});
        end
        foreach (ch_val[i]) ch_val[i] = 12'($urandom);
        settle();
        wr1(8'h0d, 8'h01);
        check_val({11'h0, pd}, 12'h001);
        for (int i = 0; i < 3; i++) begin
            note(8'hff, ch_val[i][11:4]);
            note(8'hff, {ch_val[i][3:0], 4'h0});
        end
        note(8'hff, ch_val[3][7:0]);
        foreach (ch_val[i]) ch_val[i] = ~ch_val[i];
        settle();
        rd_regs(8'h03, 7);
        wr1(8'h0d, 8'h00);
        check_val({11'h0, pd}, 12'h000);
        settle();
        complete_run();
    end
endmodule // triaxial_accel_readout_int_bench
`default_nettype wire
